// file: src/spt_pkg.sv
// Shared types and constants for the serial trigger and decode unit
package spt_pkg;
    localparam int SPT_WORD_MAX = 32;
    localparam int SPT_PAT_MAX = 32;
    localparam int SPT_NIBBLES = 8;
    localparam int SPT_CNT_W = 16;
    localparam int SPT_GAP_W = 20;
    localparam int SPT_TS_W = 32;
    localparam int SPT_LEN_W = 6;
    localparam int SPT_SYNC_W = 3;
    // Reset values and the length maximum
    localparam logic [SPT_LEN_W-1:0] SPT_LEN_RST = 6'h00;
    localparam logic [SPT_CNT_W-1:0] SPT_CNT_RST = 16'h0000;
    localparam logic [SPT_TS_W-1:0] SPT_TS_RST = 32'h00000000;
    localparam logic [SPT_LEN_W-1:0] SPT_LEN_MAX = 6'h20;
    // Polarity defaults: chip select low-active, data high-active
    localparam logic SPT_CS_LOW_DEF = 1'b1;
    localparam logic SPT_DATA_LOW_DEF = 1'b0;

    typedef enum logic [3:0] {
        SPT_TRIG_BEGIN = 4'h1,
        SPT_TRIG_FINISH = 4'h2,
        SPT_TRIG_BIT = 4'h4,
        SPT_TRIG_MATCH = 4'h8
    } spt_mode_t;

    typedef enum logic [1:0] {
        SPT_PB_ZERO = 2'h0,
        SPT_PB_ONE = 2'h1,
        SPT_PB_WILD = 2'h2
    } spt_pbit_t;

    typedef enum logic [1:0] {
        SPT_GL_HEX = 2'h0,
        SPT_GL_MIXED = 2'h1,
        SPT_GL_WILD = 2'h2,
        SPT_GL_ABSENT = 2'h3
    } spt_glyph_t;

    typedef enum logic [1:0] {
        SPT_ST_IDLE = 2'h1,
        SPT_ST_FRAME = 2'h2
    } spt_state_t;

    typedef struct packed {
        logic use_cs;
        logic cs_act_low;
        logic data_act_low;
        logic sample_fall;
        logic lsb_first;
        logic [SPT_LEN_W-1:0] word_size;
        spt_mode_t mode;
        logic [SPT_CNT_W-1:0] skip_count;
        logic [SPT_GAP_W-1:0] gap_cycles;
    } spt_cfg_t;

    typedef struct packed {
        logic [SPT_TS_W-1:0] start_rel;
        logic [SPT_CNT_W-1:0] word_count;
        logic valid;
    } spt_rec_t;
endpackage

// file: src/spt_sync.sv
// Three-stage input synchroniser with agreement filter and change pulse
`timescale 1ns/1ps
module spt_sync #(
    parameter int W = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Raw pins
    input wire logic [W-1:0] pin,
    // Filtered level and one-cycle change pulse
    output logic [W-1:0] lvl,
    output logic [W-1:0] chg
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] lvl_q;

    // Chain; first stage feeds only the second
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accept a new level only once stages two and three agree
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lvl_q <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    lvl_q[i] <= s3_q[i];
                end
            end
        end
    end

    assign lvl = lvl_q;
    assign chg = {W{1'b0}} | ((s2_q ~^ s3_q) & (s3_q ^ lvl_q));
endmodule // spt_sync

// file: src/spt_decoder.sv
// Serial link trigger and frame decode unit
`timescale 1ns/1ps
module spt_decoder
    import spt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Observed link pins
    input wire logic link_sclk,
    input wire logic link_cs,
    input wire logic link_data,
    // Configuration
    input wire spt_cfg_t cfg,
    // Pattern and length entry
    input wire logic pat_wr,
    input wire logic [4:0] pat_idx,
    input wire spt_pbit_t pat_bit,
    input wire logic match_length_cmd,
    input wire logic [SPT_LEN_W-1:0] match_length_val,
    // Trigger
    output logic trig,
    output logic [SPT_CNT_W-1:0] trig_bit,
    output logic frame_active,
    // Decoded words
    output logic word_stb,
    output logic [SPT_WORD_MAX-1:0] word_data,
    // Frame record
    output logic rec_stb,
    output spt_rec_t rec,
    // Pattern view
    output logic [SPT_LEN_W-1:0] match_length,
    output spt_glyph_t [SPT_NIBBLES-1:0] glyph
);
    logic [SPT_SYNC_W-1:0] lvl;
    logic [SPT_SYNC_W-1:0] chg;
    spt_state_t st_q;
    logic [SPT_GAP_W-1:0] gap_q;
    logic seen_q;
    logic [SPT_CNT_W-1:0] bit_num_q;
    logic mis_q;
    logic [SPT_TS_W-1:0] ts_q;
    logic [SPT_TS_W-1:0] pstart_ts_q;
    logic [SPT_TS_W-1:0] trig_ts_q;
    logic [SPT_TS_W-1:0] fbeg_ts_q;
    logic [SPT_LEN_W-1:0] wbits_q;
    logic [SPT_WORD_MAX-1:0] acc_q;
    logic [SPT_CNT_W-1:0] wcount_q;
    logic [SPT_PAT_MAX-1:0] pval_q;
    logic [SPT_PAT_MAX-1:0] pcare_q;
    logic [SPT_LEN_W-1:0] len_q;
    logic trig_q;
    logic [SPT_CNT_W-1:0] trig_bit_q;
    logic word_stb_q;
    logic [SPT_WORD_MAX-1:0] word_q;
    logic rec_stb_q;
    spt_rec_t rec_q;
    spt_glyph_t [SPT_NIBBLES-1:0] glyph_q;

    // Place one bit into the word under assembly
    function automatic logic [SPT_WORD_MAX-1:0] spt_put(input logic [SPT_WORD_MAX-1:0] acc,
                                                         input logic [SPT_LEN_W-1:0] idx,
                                                         input logic b,
                                                         input logic lsb);
        logic [SPT_WORD_MAX-1:0] r;
        r = acc;
        if (lsb) begin
            r[idx[4:0]] = b;
        end else begin
            r = {acc[SPT_WORD_MAX-2:0], b};
        end
        return r;
    endfunction

    // Classify one nibble of the pattern for display
    function automatic spt_glyph_t spt_nib(input logic [3:0] care, input int base,
                                           input logic [SPT_LEN_W-1:0] len);
        spt_glyph_t g;
        g = SPT_GL_HEX;
        if (int'(len) <= base) begin
            g = SPT_GL_ABSENT;
        end else if (int'(len) < base + 4) begin
            g = SPT_GL_MIXED;
        end else if (care == 4'h0) begin
            g = SPT_GL_WILD;
        end else if (care != 4'hF) begin
            g = SPT_GL_MIXED;
        end
        return g;
    endfunction

    spt_sync #(.W(SPT_SYNC_W)) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .pin({link_data, link_cs, link_sclk}),
        .lvl(lvl),
        .chg(chg)
    );

    // Polarity and edge selection
    logic cs_act;
    logic din;
    logic smp;
    logic gap_exp;
    logic begin_ev;
    logic finish_ev;
    logic bit_ev;
    // A change pulse comes while lvl still holds the old level, so edges judge the new one
    assign cs_act = (lvl[1] ^ chg[1]) ^ cfg.cs_act_low;
    assign din = lvl[2] ^ cfg.data_act_low;
    assign smp = chg[0] & ((lvl[0] ^ chg[0]) == ~cfg.sample_fall);
    // Gap expiry pulses once per quiet interval, on the cycle the count stands one below the gap
    assign gap_exp = (cfg.gap_cycles != '0) && (gap_q == cfg.gap_cycles - 1'b1) && !chg[0];
    assign begin_ev = cfg.use_cs ? (chg[1] & cs_act)
                                 : (gap_exp & ((st_q == SPT_ST_IDLE) | seen_q));
    assign finish_ev = cfg.use_cs ? (chg[1] & ~cs_act & (st_q == SPT_ST_FRAME))
                                  : (gap_exp & (st_q == SPT_ST_FRAME) & seen_q);
    assign bit_ev = smp & (st_q == SPT_ST_FRAME) & ~begin_ev;

    // Pattern window arithmetic
    logic [SPT_CNT_W:0] pos;
    logic in_win;
    logic mis_now;
    logic last_bit;
    logic hit;
    assign pos = {1'b0, bit_num_q} - {1'b0, cfg.skip_count};
    assign in_win = !pos[SPT_CNT_W] && (pos < {11'h000, len_q});
    assign mis_now = pcare_q[pos[4:0]] & (din != pval_q[pos[4:0]]);
    assign last_bit = (pos == {11'h000, len_q} - 17'h00001);

    // Trigger condition selected by mode
    always_comb begin
        hit = 1'b0;
        unique case (cfg.mode)
            SPT_TRIG_BEGIN: hit = begin_ev;
            SPT_TRIG_FINISH: hit = finish_ev;
            SPT_TRIG_BIT: hit = bit_ev && (bit_num_q == cfg.skip_count);
            SPT_TRIG_MATCH: hit = bit_ev && in_win && last_bit && !(mis_q | mis_now);
            default: hit = 1'b0;
        endcase
    end

    // Matched sequence is only known at its last bit; date it back to the first,
    // which is this very sample when the match length is one
    logic [SPT_TS_W-1:0] hit_ts;
    assign hit_ts = (cfg.mode == SPT_TRIG_MATCH && bit_num_q != cfg.skip_count) ? pstart_ts_q
                                                                                 : ts_q;

    // Frame state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= SPT_ST_IDLE;
        end else if (begin_ev) begin
            st_q <= SPT_ST_FRAME;
        end else if (finish_ev) begin
            st_q <= SPT_ST_IDLE;
        end
    end

    // Quiet time since the last clock edge; saturates at the gap
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gap_q <= '0;
        end else if (chg[0]) begin
            gap_q <= '0;
        end else if (gap_q < cfg.gap_cycles) begin
            gap_q <= gap_q + 1'b1;
        end
    end

    // Bit counter and compare state, cleared at every begin
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bit_num_q <= SPT_CNT_RST;
            mis_q <= 1'b0;
            seen_q <= 1'b0;
        end else if (begin_ev) begin
            bit_num_q <= SPT_CNT_RST;
            mis_q <= 1'b0;
            seen_q <= 1'b0;
        end else if (bit_ev) begin
            seen_q <= 1'b1;
            if (bit_num_q != '1) begin
                bit_num_q <= bit_num_q + 1'b1;
            end
            if (in_win) begin
                mis_q <= mis_q | mis_now;
            end
        end
    end

    // Free-running time base and captured time marks
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ts_q <= SPT_TS_RST;
            pstart_ts_q <= SPT_TS_RST;
            fbeg_ts_q <= SPT_TS_RST;
            trig_ts_q <= SPT_TS_RST;
        end else begin
            ts_q <= ts_q + 1'b1;
            if (begin_ev) begin
                fbeg_ts_q <= ts_q;
            end
            if (bit_ev && bit_num_q == cfg.skip_count) begin
                pstart_ts_q <= ts_q;
            end
            if (hit) begin
                trig_ts_q <= hit_ts;
            end
        end
    end

    // Trigger pulse and its bit position
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trig_q <= 1'b0;
            trig_bit_q <= SPT_CNT_RST;
        end else begin
            trig_q <= hit;
            if (hit) begin
                // Begin precedes every bit; finish reports the bits seen
                trig_bit_q <= (cfg.mode == SPT_TRIG_FINISH) ? bit_num_q
                            : (cfg.mode == SPT_TRIG_BEGIN) ? SPT_CNT_RST : cfg.skip_count + 1'b1;
            end
        end
    end

    // Word assembly
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wbits_q <= SPT_LEN_RST;
            acc_q <= '0;
            wcount_q <= SPT_CNT_RST;
            word_stb_q <= 1'b0;
            word_q <= '0;
        end else begin
            word_stb_q <= 1'b0;
            if (begin_ev) begin
                wbits_q <= SPT_LEN_RST;
                acc_q <= '0;
                wcount_q <= SPT_CNT_RST;
            end else if (bit_ev) begin
                if (wbits_q + 1'b1 >= cfg.word_size) begin
                    word_q <= spt_put(acc_q, wbits_q, din, cfg.lsb_first);
                    word_stb_q <= 1'b1;
                    wbits_q <= SPT_LEN_RST;
                    acc_q <= '0;
                    wcount_q <= wcount_q + 1'b1;
                end else begin
                    acc_q <= spt_put(acc_q, wbits_q, din, cfg.lsb_first);
                    wbits_q <= wbits_q + 1'b1;
                end
            end
        end
    end

    // Frame record; a trailing partial word or an empty frame marks it not valid
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rec_stb_q <= 1'b0;
            rec_q <= '0;
        end else begin
            rec_stb_q <= finish_ev;
            if (finish_ev) begin
                // A finish trigger lands in this same cycle and must already count
                rec_q.start_rel <= fbeg_ts_q - (hit ? hit_ts : trig_ts_q);
                rec_q.word_count <= wcount_q;
                rec_q.valid <= (wbits_q == '0) && (wcount_q != '0);
            end
        end
    end

    // Pattern entry with automatic length growth
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pval_q <= '0;
            pcare_q <= '0;
            len_q <= SPT_LEN_RST;
        end else begin
            if (pat_wr) begin
                pval_q[pat_idx] <= (pat_bit == SPT_PB_ONE);
                pcare_q[pat_idx] <= (pat_bit != SPT_PB_WILD);
            end
            if (pat_wr && ({1'b0, pat_idx} + 6'h01 > (match_length_cmd ?
                    match_length_val : len_q))) begin
                len_q <= {1'b0, pat_idx} + 6'h01;
            end else if (match_length_cmd) begin
                len_q <= (match_length_val > SPT_LEN_MAX) ? SPT_LEN_MAX
                                                          : match_length_val;
            end
        end
    end

    // Nibble display classes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            glyph_q <= {SPT_NIBBLES{SPT_GL_ABSENT}};
        end else begin
            for (int n = 0; n < SPT_NIBBLES; n++) begin
                glyph_q[n] <= spt_nib(pcare_q[n*4 +: 4], n * 4, len_q);
            end
        end
    end

    assign trig = trig_q;
    assign trig_bit = trig_bit_q;
    assign frame_active = (st_q == SPT_ST_FRAME);
    assign word_stb = word_stb_q;
    assign word_data = word_q;
    assign rec_stb = rec_stb_q;
    assign rec = rec_q;
    assign match_length = len_q;
    assign glyph = glyph_q;
endmodule // spt_decoder

// file: bench/spt_link_model.sv
// Behavioural model of the observed link master driving clock, select and data
`timescale 1ns/1ps
module spt_link_model (
    // Observed link pins
    output logic sclk,
    output logic cs_pin,
    output logic data_pin
);
    // Clock idles low, select idles inactive
    initial begin
        sclk = 1'b0;
        cs_pin = 1'b1;
        data_pin = 1'b0;
    end

    // One frame, first bit from bits[n-1]; 320 ns clock period, stands still between frames
    task automatic frame(input logic [31:0] bits, input int n, input logic sel, input logic inv);
        #13;
        if (sel) cs_pin = 1'b0;
        #640;
        for (int i = n - 1; i >= 0; i--) begin
            // Data moves mid-low so neither clock edge sees it change
            #80 data_pin = bits[i] ^ inv;
            #80 sclk = 1'b1;
            #160 sclk = 1'b0;
        end
        #640;
        cs_pin = 1'b1;
        data_pin = ~data_pin; // Released line has no pull, so it shows the inverse
    endtask
endmodule // spt_link_model

// file: bench/spt_decoder_monitor.sv
// Concurrent checks on the ports of the serial trigger and decode unit
`timescale 1ns/1ps
module spt_decoder_monitor
    import spt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Configuration and pattern entry
    input wire spt_cfg_t cfg,
    input wire logic pat_wr,
    input wire logic [4:0] pat_idx,
    input wire logic match_length_cmd,
    input wire logic [SPT_LEN_W-1:0] match_length_val,
    // Observed outputs
    input wire logic trig,
    input wire logic [SPT_CNT_W-1:0] trig_bit,
    input wire logic frame_active,
    input wire logic word_stb,
    input wire logic rec_stb,
    input wire logic [SPT_LEN_W-1:0] match_length
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // Strobes last one cycle so downstream counters never count twice
    trig_pulse_a: assert property (trig |=> !trig)
        else $error("trigger pulse too long");
    word_pulse_a: assert property (word_stb |=> !word_stb)
        else $error("word strobe too long");
    rec_pulse_a: assert property (rec_stb |=> !rec_stb)
        else $error("record strobe too long");
    // Select-framed records close the frame
    cs_finish_a: assert property (rec_stb && cfg.use_cs |-> !frame_active)
        else $error("frame still open at record");
    begin_fire_a: assert property ($rose(frame_active)
        && cfg.mode == SPT_TRIG_BEGIN |-> trig)
        else $error("no trigger at frame begin");
    finish_fire_a: assert property (rec_stb && cfg.mode == SPT_TRIG_FINISH |-> trig)
        else $error("no trigger at frame finish");
    pos_bit_a: assert property (trig && (cfg.mode == SPT_TRIG_BIT
        || cfg.mode == SPT_TRIG_MATCH) |-> trig_bit == cfg.skip_count + 16'h0001)
        else $error("trigger bit not after skipped bits");
    begin_bit_a: assert property (trig && cfg.mode == SPT_TRIG_BEGIN
        |-> trig_bit == 16'h0000)
        else $error("begin trigger carries a bit number");
    // Writing past the length must enlarge it to cover the written bit
    len_grow_a: assert property (pat_wr |=> match_length > $past(pat_idx))
        else $error("length not enlarged");
    len_load_a: assert property (match_length_cmd && !pat_wr |=> match_length ==
        (($past(match_length_val) > SPT_LEN_MAX) ? SPT_LEN_MAX : $past(match_length_val)))
        else $error("length load wrong");
    word_frame_a: assert property (word_stb |-> $past(frame_active))
        else $error("word outside frame");
endmodule // spt_decoder_monitor

bind spt_decoder spt_decoder_monitor mon_u (.clk, .arst_n, .cfg, .pat_wr, .pat_idx,
    .match_length_cmd, .match_length_val, .trig, .trig_bit, .frame_active, .word_stb,
    .rec_stb, .match_length);

// file: bench/spt_decoder_test.sv
// Self-checking bench for the serial trigger and decode unit
`timescale 1ns/1ps
module spt_decoder_test
    import spt_pkg::*;
;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic sclk, cs_pin, data_pin, pat_wr, match_length_cmd;
    logic trig, frame_active, word_stb, rec_stb;
    spt_cfg_t cfg;
    logic [4:0] pat_idx;
    spt_pbit_t pat_bit;
    logic [SPT_LEN_W-1:0] match_length_val, match_length;
    logic [SPT_CNT_W-1:0] trig_bit;
    logic [SPT_WORD_MAX-1:0] word_data;
    spt_rec_t rec, rec_seen;
    spt_glyph_t [SPT_NIBBLES-1:0] glyph;
    int miscompares = 0;
    int compares = 0;
    int n_trig, n_rec, k;
    logic [15:0] last_tbit;
    logic [31:0] words[$];
    spt_mode_t modes[4] = '{SPT_TRIG_BEGIN, SPT_TRIG_FINISH, SPT_TRIG_BIT, SPT_TRIG_MATCH};
    logic [15:0] exp_tbit[4] = '{16'h0000, 16'h0010, 16'h0003, 16'h0003};
    // Begin minus trigger in clocks: 0, then -160 at finish, -36 at the sample of bit 3
    logic [31:0] exp_rel[4] = '{32'h00000000, 32'hFFFFFF60, 32'hFFFFFFDC, 32'hFFFFFFDC};
    // Pattern 1001, 10X1, XXXX from index 0
    logic [1:0] pat_tab[12] = '{2'h1, 2'h0, 2'h0, 2'h1, 2'h1, 2'h0, 2'h2, 2'h1,
                                2'h2, 2'h2, 2'h2, 2'h2};

    // 25 MHz sampling clock
    always #20 clk = ~clk;

    spt_link_model link_u (.sclk(sclk), .cs_pin(cs_pin), .data_pin(data_pin));

    spt_decoder dut_u (.clk(clk), .arst_n(arst_n), .link_sclk(sclk), .link_cs(cs_pin),
        .link_data(data_pin), .cfg(cfg), .pat_wr(pat_wr), .pat_idx(pat_idx), .pat_bit(pat_bit),
        .match_length_cmd(match_length_cmd), .match_length_val(match_length_val), .trig(trig),
        .trig_bit(trig_bit), .frame_active(frame_active), .word_stb(word_stb),
        .word_data(word_data), .rec_stb(rec_stb), .rec(rec), .match_length(match_length),
        .glyph(glyph));

    // Collect strobes mid-cycle, where registered outputs have settled
    always @(negedge clk) begin
        if (trig === 1'b1) begin
            n_trig++;
            last_tbit = trig_bit;
        end
        if (word_stb === 1'b1) words.push_back({24'h000000, word_data[7:0]});
        if (rec_stb === 1'b1) begin
            n_rec++;
            rec_seen = rec;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic set_len(input logic [5:0] v);
        match_length_cmd = 1'b1;
        match_length_val = v;
        @(negedge clk);
        match_length_cmd = 1'b0;
        @(negedge clk);
    endtask

    // Sends one frame and waits, bounded, for its record
    task automatic run_frame(input logic [31:0] bits, input int n, input logic sel,
                             input logic inv);
        int w;
        n_trig = 0;
        n_rec = 0;
        words.delete();
        link_u.frame(bits, n, sel, inv);
        w = 0;
        while (n_rec == 0 && w < 400) begin
            @(negedge clk);
            w++;
        end
        if (n_rec == 0) begin
            miscompares++;
            give_verdict();
        end
        repeat (4) @(negedge clk);
    endtask

    initial begin
        cfg = '{use_cs: 1'b1, cs_act_low: SPT_CS_LOW_DEF, data_act_low: SPT_DATA_LOW_DEF,
                sample_fall: 1'b0, lsb_first: 1'b0, word_size: 6'h08, mode: SPT_TRIG_BEGIN,
                skip_count: 16'h0002, gap_cycles: 20'h00040};
        pat_wr = 1'b0;
        pat_idx = 5'h00;
        pat_bit = SPT_PB_ZERO;
        match_length_cmd = 1'b0;
        match_length_val = 6'h00;
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        chk(32'(match_length), 32'h0);
        for (int i = 0; i < 8; i++) chk(32'(glyph[i]), 32'(SPT_GL_ABSENT));
        set_len(6'h08);
        // Back-to-back writes run past the length of 8
        pat_wr = 1'b1;
        for (int i = 0; i < 12; i++) begin
            pat_idx = 5'(i);
            pat_bit = spt_pbit_t'(pat_tab[i]);
            @(negedge clk);
        end
        pat_wr = 1'b0;
        repeat (2) @(negedge clk);
        chk(32'(match_length), 32'hC);
        chk(32'(glyph[0]), 32'(SPT_GL_HEX));
        chk(32'(glyph[1]), 32'(SPT_GL_MIXED));
        chk(32'(glyph[2]), 32'(SPT_GL_WILD));
        chk(32'(glyph[3]), 32'(SPT_GL_ABSENT));
        set_len(6'h28);
        chk(32'(match_length), 32'(SPT_LEN_MAX));
        set_len(6'h04);
        // Same select-framed stream under every trigger condition
        for (int m = 0; m < 4; m++) begin
            cfg.mode = modes[m];
            run_frame(32'h000026C3, 16, 1'b1, 1'b0);
            chk(32'(n_trig), 32'h1);
            chk({16'h0000, last_tbit}, {16'h0000, exp_tbit[m]});
            chk(32'(words.size()), 32'h2);
            chk(words[0], 32'h26);
            chk(words[1], 32'hC3);
            chk(32'(rec_seen.word_count), 32'h2);
            chk(32'(rec_seen.valid), 32'h1);
            chk(rec_seen.start_rel, exp_rel[m]);
        end
        // One flipped pattern bit must hold the match trigger back
        cfg.mode = SPT_TRIG_MATCH;
        run_frame(32'h000036C3, 16, 1'b1, 1'b0);
        chk(32'(n_trig), 32'h0);
        // Partial trailing word spoils the frame
        cfg.mode = SPT_TRIG_BIT;
        run_frame(32'h0000026C, 12, 1'b1, 1'b0);
        chk(32'(rec_seen.word_count), 32'h1);
        chk(32'(rec_seen.valid), 32'h0);
        // No select: gap framing, falling sample, LSB first, inverted data
        arst_n = 1'b0;
        cfg.use_cs = 1'b0;
        cfg.sample_fall = 1'b1;
        cfg.lsb_first = 1'b1;
        cfg.data_act_low = 1'b1;
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        repeat (32) @(negedge clk);
        chk(32'(frame_active), 32'h0);
        k = 0;
        while (frame_active !== 1'b1 && k < 200) begin
            @(negedge clk);
            k++;
        end
        chk(32'(frame_active), 32'h1);
        run_frame(32'h000026C3, 16, 1'b0, 1'b1);
        chk({16'h0000, last_tbit}, 32'h3);
        chk(words[0], 32'h64);
        chk(words[1], 32'hC3);
        chk(32'(rec_seen.word_count), 32'h2);
        chk(32'(frame_active), 32'h1);
        give_verdict();
    end
endmodule // spt_decoder_test
